// File: rss_pkg.sv
// package for the reference step sequencer: constants, types and the step function
package rss_pkg;
  // clock rate and timing
  localparam int unsigned REF_CLK_KHZ = 50000;
  localparam int unsigned CODE_CLK_KHZ = 1800;
  localparam int unsigned CS_HALF_CYC = REF_CLK_KHZ / (2 * CODE_CLK_KHZ);
  localparam int unsigned MASK_DELAY_NS = 15000;
  localparam int unsigned MASK_DELAY_CYC = (MASK_DELAY_NS * REF_CLK_KHZ) / 1000000;
  localparam int unsigned INIT_DELAY_US = 1500;
  localparam int unsigned INIT_DELAY_CYC = INIT_DELAY_US * REF_CLK_KHZ / 1000;
  localparam int unsigned BOOT_HOLD_US = 200;
  localparam int unsigned BOOT_HOLD_CYC = BOOT_HOLD_US * REF_CLK_KHZ / 1000;
  // reference levels, in code steps of one lsb
  localparam int unsigned LSB_UV = 6250;
  localparam int unsigned BOOT_MV = 1081;
  localparam int unsigned UV_ENABLE_MV = 600;
  localparam logic [7:0] BOOT_CODE = 8'((BOOT_MV * 1000) / LSB_UV);
  localparam logic [7:0] UV_ENABLE_CODE = 8'((UV_ENABLE_MV * 1000) / LSB_UV);
  // register map and reset values
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] LEVEL_OFFSET = 12'h008;
  localparam logic [15:0] SS_PERIOD_RST = 16'h01F4;
  localparam int unsigned SS_PERIOD_POS = 0;
  localparam int unsigned LEVEL_REF_POS = 0;
  localparam int unsigned LEVEL_TARGET_POS = 8;
  localparam int unsigned LEVEL_CODE_POS = 16;

  typedef enum logic [5:0] {
    ST_OFF       = 6'h01,
    ST_DELAY     = 6'h02,
    ST_RAMP_BOOT = 6'h04,
    ST_HOLD      = 6'h08,
    ST_RAMP_PROG = 6'h10,
    ST_RUN       = 6'h20
  } rss_state_t;

  typedef struct packed {
    logic ovp_en;
    logic uvp_en;
    logic ocp_boost;
  } rss_trip_t;

  typedef struct packed {
    logic [7:0] code;
    logic enable;
    logic supply_logic;
    logic supply_drive;
    logic ovp_det;
    logic uvp_det;
    logic loop_high;
    logic loop_low;
  } rss_pins_t;

  function automatic logic [7:0] rss_step(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      return cur + 8'h01;
    end
    if (cur > tgt) begin
      return cur - 8'h01;
    end
    return cur;
  endfunction
endpackage

// File: rss_top.sv
// reference step sequencer: soft-start, dynamic code stepping, trip masking, apb registers
//
// Behaviour
// - mask over- and undervoltage trips during code transitions, plus 15 us afterwards
// - raise overcurrent limit to 150 percent during transitions and 15 us after
// - detect code change at code-step rising edge, confirm at following falling edge
// - from next rising edge step reference one lsb per cycle toward target
// - ignore code changes during a transition; resume watching next rising edge after
// - code-step clock runs at about 1.9 MHz (reference clock divided by 26)
// - logic supply below threshold: shut down, both switches off
// - releasing output enable with valid supplies starts soft-start
// - enable low clears faults, holds softstart done low, switches off
// - soft-start begins only with all supplies valid and enable released
// - wait initial delay of 1.5 ms before ramping reference from zero
// - ramp reference from zero to the 1.081 V boot level
// - hold boot level 200 us while sampling the code lines
// - then ramp to sampled code at the same step rate
// - a code below boot level makes the reference ramp downward
// - softstart done output rises only when the sequence completes
// - in soft-start undervoltage enables at 0.6 V; overvoltage always enabled
// - soft-start steps come from own oscillator whose rate is programmed
// - after soft-start rate_pin_boost_o goes high; the programmed rate setting is then unused
// - low-side switch kept off from the loop until high side has switched
// - overvoltage fault can still turn the low-side switch on
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module rss_top import rss_pkg::*; #(
  parameter int unsigned INIT_DELAY_CYC_P = INIT_DELAY_CYC,
  parameter int unsigned BOOT_HOLD_CYC_P = BOOT_HOLD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] voltage_code_i,
  input wire logic output_enable_pin_i,
  input wire logic supply_logic_ok_i,
  input wire logic supply_drive_ok_i,
  input wire logic overvoltage_detect_i,
  input wire logic undervoltage_detect_i,
  input wire logic loop_high_request_i,
  input wire logic loop_low_request_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] reference_o,
  output rss_trip_t trip_o,
  output logic high_side_switch_o,
  output logic low_side_switch_o,
  output logic softstart_done_o,
  output logic rate_pin_boost_o
);
  rss_pins_t pin_raw;
  rss_pins_t pin_s1;
  rss_pins_t pin_s;
  rss_state_t state;
  logic [7:0] ref_code;
  logic [7:0] target;
  logic [7:0] cand;
  logic pend;
  logic conf;
  logic dyn_active;
  logic [16:0] timer;
  logic uv_armed;
  logic ls_released;
  logic fault_ovp;
  logic fault_uvp;
  logic [9:0] post_cnt;
  logic [3:0] cs_cnt;
  logic cs_phase;
  logic cs_rise;
  logic cs_fall;
  logic [15:0] ss_period;
  logic [15:0] ss_cnt;
  logic ss_tick;
  logic in_ramp;
  logic run_en;
  rss_trip_t next_trip;

  assign pin_raw = '{voltage_code_i, output_enable_pin_i, supply_logic_ok_i, supply_drive_ok_i,
                     overvoltage_detect_i, undervoltage_detect_i, loop_high_request_i, loop_low_request_i};

  // two-stage synchroniser; only pin_s is read by logic
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_s1 <= '0;
      pin_s <= '0;
    end else if (ce_i) begin
      pin_s1 <= pin_raw;
      pin_s <= pin_s1;
    end
  end

  assign run_en = pin_s.enable && pin_s.supply_logic && pin_s.supply_drive;

  // free-running code-step clock derived by dividing the reference clock
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cs_cnt <= '0;
      cs_phase <= 1'b0;
    end else if (ce_i) begin
      if (cs_cnt == 4'(CS_HALF_CYC - 1)) begin
        cs_cnt <= '0;
        cs_phase <= ~cs_phase;
      end else begin
        cs_cnt <= cs_cnt + 4'h1;
      end
    end
  end
  assign cs_rise = (cs_cnt == 4'(CS_HALF_CYC - 1)) && !cs_phase;
  assign cs_fall = (cs_cnt == 4'(CS_HALF_CYC - 1)) && cs_phase;

  // soft-start oscillator: one tick per programmed period, only while ramping
  assign in_ramp = (state == ST_RAMP_BOOT) || (state == ST_RAMP_PROG);
  assign ss_tick = in_ramp && (ss_cnt >= ((ss_period == 16'h0000) ? 16'h0000 : ss_period - 16'h0001));
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ss_cnt <= '0;
    end else if (ce_i) begin
      if (!in_ramp || ss_tick) begin
        ss_cnt <= '0;
      end else begin
        ss_cnt <= ss_cnt + 16'h0001;
      end
    end
  end

  // sequencer: soft-start phases and dynamic code stepping
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= ST_OFF;
      ref_code <= '0;
      target <= '0;
      cand <= '0;
      pend <= 1'b0;
      conf <= 1'b0;
      dyn_active <= 1'b0;
      timer <= '0;
      uv_armed <= 1'b0;
      ls_released <= 1'b0;
    end else if (ce_i) begin
      if (!run_en) begin
        state <= ST_OFF;
        ref_code <= '0;
        pend <= 1'b0;
        conf <= 1'b0;
        dyn_active <= 1'b0;
        timer <= '0;
        uv_armed <= 1'b0;
        ls_released <= 1'b0;
      end else begin
        if (pin_s.loop_high && state != ST_OFF) begin
          ls_released <= 1'b1;
        end
        if (ref_code >= UV_ENABLE_CODE) begin
          uv_armed <= 1'b1;
        end
        case (state)
          ST_OFF: begin
            state <= ST_DELAY;
            timer <= '0;
          end
          ST_DELAY: begin
            if (timer == 17'(INIT_DELAY_CYC_P - 1)) begin
              state <= ST_RAMP_BOOT;
              timer <= '0;
            end else begin
              timer <= timer + 17'h00001;
            end
          end
          ST_RAMP_BOOT: begin
            if (ref_code == BOOT_CODE) begin
              state <= ST_HOLD;
            end else if (ss_tick) begin
              ref_code <= rss_step(ref_code, BOOT_CODE);
            end
          end
          ST_HOLD: begin
            target <= pin_s.code;
            if (timer == 17'(BOOT_HOLD_CYC_P - 1)) begin
              state <= ST_RAMP_PROG;
              timer <= '0;
            end else begin
              timer <= timer + 17'h00001;
            end
          end
          ST_RAMP_PROG: begin
            if (ref_code == target) begin
              state <= ST_RUN;
            end else if (ss_tick) begin
              ref_code <= rss_step(ref_code, target);
            end
          end
          ST_RUN: begin
            // the code-step clock sets the slope: one lsb per rising edge toward target
            if (cs_rise) begin
              if (dyn_active) begin
                if (ref_code == target) begin
                  dyn_active <= 1'b0;
                end else begin
                  ref_code <= rss_step(ref_code, target);
                end
              end else if (conf) begin
                target <= cand;
                ref_code <= rss_step(ref_code, cand);
                dyn_active <= 1'b1;
                conf <= 1'b0;
              end else if (pin_s.code != target) begin
                cand <= pin_s.code;
                pend <= 1'b1;
              end
            end else if (cs_fall && pend) begin
              pend <= 1'b0;
              conf <= (pin_s.code == cand);
            end
          end
          default: begin
            state <= ST_OFF;
          end
        endcase
      end
    end
  end

  // post-transition hold of masks and raised limit
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      post_cnt <= '0;
    end else if (ce_i) begin
      if (!run_en) begin
        post_cnt <= '0;
      end else if (dyn_active) begin
        post_cnt <= 10'(MASK_DELAY_CYC);
      end else if (post_cnt != 10'h000) begin
        post_cnt <= post_cnt - 10'h001;
      end
    end
  end

  always_comb begin
    next_trip = '0;
    case (state)
      ST_DELAY, ST_RAMP_BOOT, ST_HOLD, ST_RAMP_PROG: begin
        next_trip.ovp_en = 1'b1;
        next_trip.uvp_en = uv_armed;
      end
      ST_RUN: begin
        next_trip.ovp_en = !dyn_active && (post_cnt == 10'h000);
        next_trip.uvp_en = !dyn_active && (post_cnt == 10'h000);
        next_trip.ocp_boost = dyn_active || (post_cnt != 10'h000);
      end
      default: begin
        next_trip = '0;
      end
    endcase
  end

  // latched faults; enable low or logic supply loss clears them
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fault_ovp <= 1'b0;
      fault_uvp <= 1'b0;
    end else if (ce_i) begin
      if (!pin_s.enable || !pin_s.supply_logic) begin
        fault_ovp <= 1'b0;
        fault_uvp <= 1'b0;
      end else if (state != ST_OFF) begin
        if (pin_s.ovp_det && next_trip.ovp_en) begin
          fault_ovp <= 1'b1;
        end
        if (pin_s.uvp_det && next_trip.uvp_en) begin
          fault_uvp <= 1'b1;
        end
      end
    end
  end

  // registered outputs to the drivers and the analog side
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reference_o <= '0;
      trip_o <= '0;
      high_side_switch_o <= 1'b0;
      low_side_switch_o <= 1'b0;
      softstart_done_o <= 1'b0;
      rate_pin_boost_o <= 1'b0;
    end else if (ce_i) begin
      reference_o <= ref_code;
      trip_o <= next_trip;
      high_side_switch_o <= run_en && state != ST_OFF && !fault_ovp && !fault_uvp && pin_s.loop_high;
      // an overvoltage fault overrides the startup gating of the low side
      low_side_switch_o <= (pin_s.supply_logic && pin_s.enable && fault_ovp) ||
                           (run_en && state != ST_OFF && !fault_uvp && ls_released && pin_s.loop_low);
      softstart_done_o <= run_en && (state == ST_RUN);
      rate_pin_boost_o <= run_en && (state == ST_RUN);
    end
  end

  // apb slave: no wait states; read data are registered in the setup phase so that they come from a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ss_period <= SS_PERIOD_RST;
    end else if (ce_i) begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !(paddr == CTRL_OFFSET || paddr == STATUS_OFFSET || paddr == LEVEL_OFFSET);
        case (paddr)
          CTRL_OFFSET: prdata <= 32'(ss_period) << SS_PERIOD_POS;
          STATUS_OFFSET: prdata <= 32'({state, dyn_active, fault_ovp, fault_uvp, ls_released, softstart_done_o});
          LEVEL_OFFSET: prdata <= (32'(pin_s.code) << LEVEL_CODE_POS) | (32'(target) << LEVEL_TARGET_POS) |
                                  (32'(ref_code) << LEVEL_REF_POS);
          default: prdata <= '0;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET) begin
        ss_period <= pwdata[SS_PERIOD_POS +: 16];
      end
    end
  end

  // checks
  dyn_mask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && state == ST_RUN && dyn_active |=> !trip_o.ovp_en && !trip_o.uvp_en)
    else $error("trips enabled during code transition");
  post_mask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && run_en && $fell(dyn_active) |-> post_cnt == 10'(MASK_DELAY_CYC) ##1 !trip_o.ovp_en)
    else $error("trip mask hold not started after transition");
  ocp_boost_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && state == ST_RUN && (dyn_active || post_cnt != 10'h000) |=> trip_o.ocp_boost)
    else $error("overcurrent limit not raised");
  confirm_step_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && state == ST_RUN && !dyn_active && conf && cs_rise && run_en |=> dyn_active && target == $past(cand))
    else $error("confirmed code not started on rising edge");
  one_lsb_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ref_code != $past(ref_code) && run_en && $past(run_en) |->
    (ref_code == $past(ref_code) + 8'h01) || (ref_code == $past(ref_code) - 8'h01))
    else $error("reference moved by more than one lsb");
  ignore_code_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && run_en && state == ST_RUN && dyn_active |=> target == $past(target))
    else $error("target changed during transition");
  supply_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && !pin_s.supply_logic |=> !high_side_switch_o && !low_side_switch_o)
    else $error("switch on without logic supply");
  enable_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && !pin_s.enable |=> !softstart_done_o && !fault_ovp && !fault_uvp)
    else $error("enable low did not clear state");
  init_delay_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_DELAY |-> ref_code == 8'h00)
    else $error("reference moved during initial delay");
  boot_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_HOLD |-> ref_code == BOOT_CODE)
    else $error("reference left boot level during hold");
  uv_enable_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && run_en && in_ramp && !uv_armed && ref_code < UV_ENABLE_CODE |=> !trip_o.uvp_en && trip_o.ovp_en)
    else $error("soft-start trip enables wrong");
  ls_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && !ls_released && !fault_ovp |=> !low_side_switch_o)
    else $error("low side switched before high side");
  ovp_ls_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && fault_ovp && pin_s.enable && pin_s.supply_logic |=> low_side_switch_o && !high_side_switch_o)
    else $error("overvoltage fault did not force low side");
  done_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(softstart_done_o) |-> $past(state) == ST_RUN)
    else $error("softstart done before sequence end");
  cov_softstart_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(softstart_done_o));
  cov_dyn_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) $fell(dyn_active) ##1 post_cnt != 10'h000);
  cov_down_c: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    state == ST_RAMP_PROG && target < BOOT_CODE && ss_tick);
  cov_ovp_c: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(fault_ovp));
endmodule

// File: rss_platform_model.sv
// platform model that drives the voltage code, the enable pin and the supply flags
`timescale 1ns/1ns
module rss_platform_model (
  input wire logic ref_clk_i,
  output logic [7:0] voltage_code_o,
  output logic output_enable_pin_o,
  output logic supply_logic_ok_o,
  output logic supply_drive_ok_o
);
  initial begin
    voltage_code_o = 8'h00;
    output_enable_pin_o = 1'b0;
    supply_logic_ok_o = 1'b0;
    supply_drive_ok_o = 1'b0;
  end

  task automatic set_power(input logic logic_ok, input logic drive_ok, input logic enable);
    @(posedge ref_clk_i);
    supply_logic_ok_o <= logic_ok;
    supply_drive_ok_o <= drive_ok;
    output_enable_pin_o <= enable;
  endtask

  // pace 0 jumps at once; otherwise one lsb every pace cycles sets the output slope
  task automatic move_code(input logic [7:0] target, input int pace);
    logic [7:0] cur;
    cur = voltage_code_o;
    while (cur != target) begin
      @(posedge ref_clk_i);
      cur = (pace == 0) ? target : ((cur < target) ? cur + 8'h01 : cur - 8'h01);
      voltage_code_o <= cur;
      repeat ((pace > 1) ? pace - 1 : 0) @(posedge ref_clk_i);
    end
  endtask
endmodule

// File: rss_tb_top.sv
// self-checking bench for the reference step sequencer
`timescale 1ns/1ns
module rss_tb_top import rss_pkg::*;;
  localparam int INIT_CYC = 20;
  localparam int HOLD_CYC = 10;
  localparam int TICK = 4;
  localparam int STEP_CYC = 26;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ov_det = 1'b0, uv_det = 1'b0, loop_hi = 1'b0, loop_lo = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, hs, ls, done, boost, en, sup_l, sup_d, err;
  logic [7:0] code, ref_lvl;
  rss_trip_t trip;
  int num_errors = 0;
  int samples_checked = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  rss_platform_model rss_platform_model_i (.ref_clk_i(ref_clk_i), .voltage_code_o(code),
    .output_enable_pin_o(en), .supply_logic_ok_o(sup_l), .supply_drive_ok_o(sup_d));
  // short delays keep the run brief; expectations use the same values
  rss_top #(.INIT_DELAY_CYC_P(INIT_CYC), .BOOT_HOLD_CYC_P(HOLD_CYC)) rss_top_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce), .voltage_code_i(code), .output_enable_pin_i(en),
    .supply_logic_ok_i(sup_l), .supply_drive_ok_i(sup_d), .overvoltage_detect_i(ov_det),
    .undervoltage_detect_i(uv_det), .loop_high_request_i(loop_hi), .loop_low_request_i(loop_lo), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_o(ref_lvl), .trip_o(trip), .high_side_switch_o(hs), .low_side_switch_o(ls),
    .softstart_done_o(done), .rate_pin_boost_o(boost));

  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a bounded wait that ran out ends the run
  task automatic bound(input bit ok, input string msg);
    check(ok, msg);
    if (!ok) complete_run();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bound(pready === 1'b1, "apb answer missing");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // follows the reference to tgt; every move is one lsb, spaced by period after the first
  task automatic wait_ref(input logic [7:0] tgt, input int period, input bit ss);
    int n, gap, steps;
    logic [7:0] last;
    n = 0;
    gap = 0;
    steps = 0;
    last = ref_lvl;
    while (ref_lvl !== tgt) begin
      @(negedge ref_clk_i);
      n++;
      gap++;
      if (ss && ref_lvl !== 8'h00) begin
        check(trip.ovp_en === 1'b1 && {ls, done, boost} === 3'b000, "soft-start trip or switch state");
        if (ref_lvl < 8'h5F) check(trip.uvp_en === 1'b0, "undervoltage trip enabled too early");
        if (ref_lvl > 8'h61) check(trip.uvp_en === 1'b1, "undervoltage trip not enabled");
      end
      if (ref_lvl !== last) begin
        check(ref_lvl === last + 8'h01 || ref_lvl === last - 8'h01, "reference jumped");
        if (steps > 0 && period > 0) check(gap == period, "step spacing wrong");
        steps++;
        gap = 0;
        last = ref_lvl;
      end
      if (n > 20000) bound(1'b0, "reference never reached target");
    end
  endtask

  task automatic test_regs();
    check({hs, ls, done, boost, ref_lvl, trip} === 15'h0, "outputs not clear after reset");
    apb(1'b0, 12'h000, 32'h0);
    check(rd === 32'h0000_01F4 && err === 1'b0, "rate setting reset value");
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    check(err === 1'b0, "status write flagged");
    apb(1'b0, 12'h004, 32'h0);
    check(rd[10:0] === 11'h020, "idle status wrong or changed by write");
    apb(1'b0, 12'h00C, 32'h0);
    check(err === 1'b1 && rd === 32'h0, "unmapped read accepted");
    apb(1'b1, 12'h000, 32'(TICK));
    apb(1'b0, 12'h000, 32'h0);
    check(rd[15:0] === 16'(TICK), "rate setting not written");
    $display("test_regs done");
  endtask

  task automatic test_softstart();
    int n;
    @(posedge ref_clk_i);
    loop_lo <= 1'b1;
    rss_platform_model_i.move_code(8'hC8, 0);
    rss_platform_model_i.set_power(1'b1, 1'b0, 1'b1);
    repeat (60) @(negedge ref_clk_i);
    check(ref_lvl === 8'h00 && done === 1'b0, "start without driver supply");
    rss_platform_model_i.set_power(1'b1, 1'b1, 1'b1);
    for (n = 0; n < 200 && ref_lvl === 8'h00; n++) @(negedge ref_clk_i);
    check(n >= INIT_CYC && n < INIT_CYC + TICK + 8, "initial delay length");
    wait_ref(BOOT_CODE, TICK, 1'b1);
    repeat (HOLD_CYC - 2) @(negedge ref_clk_i);
    check(ref_lvl === BOOT_CODE, "boot hold too short");
    wait_ref(8'hC8, TICK, 1'b1);
    for (n = 0; n < 10 && done !== 1'b1; n++) @(negedge ref_clk_i);
    bound(done === 1'b1 && boost === 1'b1, "soft-start end not flagged");
    @(posedge ref_clk_i);
    loop_hi <= 1'b1;
    for (n = 0; n < 8 && ls !== 1'b1; n++) @(negedge ref_clk_i);
    bound(hs === 1'b1 && ls === 1'b1, "switches not released to the loop");
    $display("test_softstart done");
  endtask

  task automatic test_dynamic();
    int n;
    rss_platform_model_i.move_code(8'hCB, 0);
    wait_ref(8'hC9, STEP_CYC, 1'b0);
    check(trip === 3'b001, "trips not masked or limit not raised");
    // a trip pulse inside the transition must not latch a fault
    @(posedge ref_clk_i);
    ov_det <= 1'b1;
    uv_det <= 1'b1;
    @(posedge ref_clk_i);
    ov_det <= 1'b0;
    uv_det <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    check({hs, ls} === 2'b11, "masked trip latched a fault");
    // clock enable low must freeze the stepping for longer than a code-step period
    @(posedge ref_clk_i);
    ce <= 1'b0;
    repeat (40) @(negedge ref_clk_i);
    check(ref_lvl === 8'hC9 && trip === 3'b001, "state moved with clock enable low");
    @(posedge ref_clk_i);
    ce <= 1'b1;
    wait_ref(8'hCA, STEP_CYC, 1'b0);
    rss_platform_model_i.move_code(8'hCE, 0);
    wait_ref(8'hCB, STEP_CYC, 1'b0);
    repeat (STEP_CYC + 4) @(negedge ref_clk_i);
    check(ref_lvl === 8'hCB, "code change taken mid-transition");
    wait_ref(8'hCE, STEP_CYC, 1'b0);
    for (n = 0; n < 1000 && trip !== 3'b110; n++) @(negedge ref_clk_i);
    check(n >= 750 && n < 800, "mask release delay");
    // pulses shorter than half a code-step period must never be confirmed
    for (n = 0; n < 6; n++) begin
      rss_platform_model_i.move_code(8'h5A, 0);
      repeat (4) @(posedge ref_clk_i);
      rss_platform_model_i.move_code(8'hCE, 0);
      repeat (25) @(posedge ref_clk_i);
    end
    repeat (60) @(negedge ref_clk_i);
    check(ref_lvl === 8'hCE && trip === 3'b110, "short code pulse accepted");
    @(posedge ref_clk_i);
    uv_det <= 1'b1;
    @(posedge ref_clk_i);
    uv_det <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    check({hs, ls} === 2'b00, "unmasked undervoltage not latched");
    $display("test_dynamic done");
  endtask

  task automatic test_faults();
    int n;
    @(posedge ref_clk_i);
    loop_hi <= 1'b0;
    rss_platform_model_i.set_power(1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    check({hs, ls, done, ref_lvl} === 11'h0, "enable low left sequence running");
    rss_platform_model_i.move_code(8'h64, 0);
    rss_platform_model_i.set_power(1'b1, 1'b1, 1'b1);
    wait_ref(8'h10, TICK, 1'b1);
    @(posedge ref_clk_i);
    ov_det <= 1'b1;
    @(posedge ref_clk_i);
    ov_det <= 1'b0;
    for (n = 0; n < 8 && ls !== 1'b1; n++) @(negedge ref_clk_i);
    bound(ls === 1'b1 && hs === 1'b0, "overvoltage did not turn the low side on");
    rss_platform_model_i.set_power(1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    check({hs, ls, done, ref_lvl} === 11'h0, "enable low kept fault or switches");
    rss_platform_model_i.set_power(1'b1, 1'b1, 1'b1);
    wait_ref(BOOT_CODE, TICK, 1'b1);
    wait_ref(8'h64, TICK, 1'b1);
    for (n = 0; n < 10 && done !== 1'b1; n++) @(negedge ref_clk_i);
    bound(done === 1'b1, "soft-start end not flagged");
    @(posedge ref_clk_i);
    loop_hi <= 1'b1;
    repeat (6) @(negedge ref_clk_i);
    check(hs === 1'b1, "high side not following loop");
    rss_platform_model_i.set_power(1'b0, 1'b1, 1'b1);
    repeat (6) @(negedge ref_clk_i);
    check({hs, ls, done, ref_lvl} === 11'h0, "low logic supply left device running");
    $display("test_faults done");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    test_regs();
    test_softstart();
    test_dynamic();
    test_faults();
    complete_run();
  end
endmodule
